// >>> uhb_pkg.sv
package uhb_pkg;

  // one-hot burst states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ACK  = 7'h02,
    S_RX   = 7'h04,
    S_TX   = 7'h08,
    S_TERM = 7'h10,
    S_CRC  = 7'h20,
    S_END  = 7'h40
  } uhb_state_e;

  // cable outputs driven by the host
  typedef struct packed {
    logic        ack_n;
    logic        stop;
    logic        rdy_strb_n;
    logic        dd_oe;
    logic [15:0] dd_out;
  } uhb_cable_s;

  localparam logic [2:0]  MODE_RST  = 3'h1;
  localparam logic [1:0]  MODE_BAD  = 2'h3;
  localparam logic [3:0]  HALF_M0   = 4'h8;
  localparam logic [3:0]  HALF_M1   = 4'h6;
  localparam logic [3:0]  HALF_M2   = 4'h4;
  localparam logic [15:0] CRC_SEED  = 16'h4aba;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam int          S2L_W     = 10;
  localparam int          L2S_W     = 5;
  localparam logic [S2L_W-1:0] S2L_RST = 10'h000;
  localparam logic [L2S_W-1:0] L2S_RST = 5'h00;
  localparam logic [3:0]  TMR_ZERO  = 4'h0;
  localparam logic [3:0]  TMR_ONE   = 4'h1;

endpackage : uhb_pkg

// >>> uhb_port.sv
`timescale 1ns/1ns
// How it works
// - modes zero, one and two selectable
// - mode held one-hot, changed only idle
// - host ready raised to pause reads
// - host strobe both edges carry write words
// - host raises stop to end bursts
// - drive strobe both edges carry read words
// - strobe comes from data driver
// - lines return to idle levels after burst
// - start, transfer, then termination phase
// - read start: ack, release, ready
// - read pause by either side
// - drive-ended read closes with host crc
// - host-ended read closes with host crc
// - write start: ack, stop low, words
// - write pause by either side
// - drive-ended write, strobe high, crc
// - host-ended write, strobe high, crc
module uhb_port
  import uhb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        link_clk,
  input  wire logic [1:0]  mode_sel,
  input  wire logic        mode_load,
  input  wire logic        burst_en,
  input  wire logic        wr_dir,
  input  wire logic        stop_req,
  input  wire logic        rx_hold,
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [15:0]      rx_data,
  output logic             rx_valid,
  output logic [2:0]       mode_oh,
  output logic             busy,
  output logic             burst_done,
  input  wire logic        drive_dma_request_pin,
  input  wire logic        dev_rdy_strb_pin,
  input  wire logic [15:0] dd_in,
  output uhb_cable_s       cable
);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction : crc_step

  // system side registers
  logic [15:0]      tx_word;
  logic             tx_tgl;
  logic             rx_seen;
  logic             done_seen;
  logic [L2S_W-1:0] l2s_1;
  logic [L2S_W-1:0] l2s_2;
  // link side registers
  logic [S2L_W-1:0] s2l_1;
  logic [S2L_W-1:0] s2l_2;
  uhb_state_e       st;
  logic [3:0]       tmr;
  logic [3:0]       half;
  logic             dir;
  logic             ld;
  logic [15:0]      crc;
  logic [15:0]      rxw;
  logic             rx_tgl;
  logic             txa;
  logic             done_tgl;
  logic             rq_1;
  logic             rq_2;
  logic             dv_1;
  logic             dv_2;
  logic             dv_3;
  logic [15:0]      dd_1;
  logic [15:0]      dd_2;
  logic             lbusy;

  // system domain decode
  wire       busy_s  = l2s_2[4];
  wire       done_s  = l2s_2[3];
  wire       rx_s    = l2s_2[2];
  wire       txa_s   = l2s_2[1];
  wire       mode_ok = mode_load && !busy_s && (mode_sel != MODE_BAD);
  wire [2:0] mode_nx = 3'h1 << mode_sel;
  wire       tx_take = tx_valid && tx_ready && ce;

  assign tx_ready = (tx_tgl == txa_s);
  assign busy     = busy_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      l2s_1 <= L2S_RST;
      l2s_2 <= L2S_RST;
    end else begin
      l2s_1 <= {lbusy, done_tgl, rx_tgl, txa, 1'b0};
      l2s_2 <= l2s_1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_oh <= MODE_RST;
    end else if (ce && mode_ok) begin
      mode_oh <= mode_nx;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_word <= 16'h0000;
      tx_tgl  <= 1'b0;
    end else if (tx_take) begin
      tx_word <= tx_data;
      tx_tgl  <= ~tx_tgl;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_seen    <= 1'b0;
      rx_valid   <= 1'b0;
      rx_data    <= 16'h0000;
      done_seen  <= 1'b0;
      burst_done <= 1'b0;
    end else if (ce) begin
      rx_valid   <= (rx_s != rx_seen);
      rx_seen    <= rx_s;
      burst_done <= (done_s != done_seen);
      done_seen  <= done_s;
      if (rx_s != rx_seen) begin
        rx_data <= rxw;
      end
    end
  end

  // link domain decode
  wire       ce_l    = s2l_2[9];
  wire       en_l    = s2l_2[8];
  wire       wr_l    = s2l_2[7];
  wire       stop_l  = s2l_2[6];
  wire       hold_l  = s2l_2[5];
  wire       txt_l   = s2l_2[4];
  wire       rxa_l   = s2l_2[3];
  wire [2:0] mode_l  = s2l_2[2:0];
  wire       rx_pend = (rx_tgl != rxa_l);
  wire       tx_pend = (txt_l != txa);
  wire       dstr_ev = dv_2 ^ dv_3;
  wire       ddm_rdy = !dv_2;
  wire       t_done  = (tmr == TMR_ZERO);
  wire       t_one   = (tmr == TMR_ONE);
  wire [3:0] half_nx = mode_l[2] ? HALF_M2 : (mode_l[1] ? HALF_M1 : HALF_M0);
  wire       rx_end  = !rq_2 || stop_l;
  wire       tx_fire = tx_pend && ddm_rdy && t_done;

  assign lbusy = ~st[0];

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      s2l_1 <= S2L_RST;
      s2l_2 <= S2L_RST;
      rq_1  <= 1'b0;
      rq_2  <= 1'b0;
      dv_1  <= 1'b1;
      dv_2  <= 1'b1;
      dv_3  <= 1'b1;
      dd_1  <= 16'h0000;
      dd_2  <= 16'h0000;
    end else begin
      s2l_1 <= {ce, burst_en, wr_dir, stop_req, rx_hold, tx_tgl, rx_seen, mode_oh};
      s2l_2 <= s2l_1;
      rq_1  <= drive_dma_request_pin;
      rq_2  <= rq_1;
      dv_1  <= dev_rdy_strb_pin;
      dv_2  <= dv_1;
      dv_3  <= dv_2;
      dd_1  <= dd_in;
      dd_2  <= dd_1;
    end
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      st       <= S_IDLE;
      cable    <= '{ack_n: 1'b1, stop: 1'b1, rdy_strb_n: 1'b1, dd_oe: 1'b0, dd_out: 16'h0000};
      tmr      <= TMR_ZERO;
      half     <= HALF_M0;
      dir      <= 1'b0;
      ld       <= 1'b0;
      crc      <= CRC_SEED;
      rxw      <= 16'h0000;
      rx_tgl   <= 1'b0;
      txa      <= 1'b0;
      done_tgl <= 1'b0;
    end else if (ce_l) begin
      if (!t_done) begin
        tmr <= tmr - TMR_ONE;
      end
      case (st)
        S_IDLE: begin
          if (en_l && rq_2) begin
            st          <= S_ACK;
            cable.ack_n <= 1'b0;
            half        <= half_nx;
            tmr         <= half_nx;
            dir         <= wr_l;
            crc         <= CRC_SEED;
            ld          <= 1'b0;
          end
        end
        S_ACK: begin
          if (t_done) begin
            cable.stop <= 1'b0;
            if (dir) begin
              st               <= S_TX;
              cable.dd_oe      <= 1'b1;
              cable.rdy_strb_n <= 1'b1;
            end else begin
              st               <= S_RX;
              cable.dd_oe      <= 1'b0;
              cable.rdy_strb_n <= hold_l || rx_pend;
            end
          end
        end
        S_RX: begin
          if (dstr_ev) begin
            rxw    <= dd_2;
            rx_tgl <= ~rx_tgl;
            crc    <= crc_step(crc, dd_2);
          end
          if (rx_end) begin
            st               <= S_TERM;
            cable.stop       <= 1'b1;
            cable.rdy_strb_n <= 1'b1;
          end else begin
            cable.rdy_strb_n <= hold_l || rx_pend || dstr_ev;
          end
        end
        S_TX: begin
          if (!rq_2 || stop_l) begin
            st               <= S_TERM;
            cable.stop       <= 1'b1;
            cable.rdy_strb_n <= 1'b1;
          end else if (tx_fire && !ld) begin
            cable.dd_out <= tx_word;
            ld           <= 1'b1;
            tmr          <= half;
          end else if (tx_fire) begin
            cable.rdy_strb_n <= ~cable.rdy_strb_n;
            crc              <= crc_step(crc, cable.dd_out);
            txa              <= ~txa;
            ld               <= 1'b0;
            tmr              <= half;
          end
        end
        S_TERM: begin
          if (!rq_2) begin
            st           <= S_CRC;
            cable.dd_oe  <= 1'b1;
            cable.dd_out <= crc;
            tmr          <= half;
          end
        end
        S_CRC: begin
          if (t_done) begin
            st          <= S_END;
            cable.ack_n <= 1'b1;
            tmr         <= half;
          end
        end
        S_END: begin
          if (t_done) begin
            st          <= S_IDLE;
            cable.dd_oe <= 1'b0;
            done_tgl    <= ~done_tgl;
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  sequence s_crc_shown;
    st == S_CRC && cable.dd_oe && cable.dd_out == crc;
  endsequence

  sequence s_ack_drop;
    $rose(cable.ack_n);
  endsequence

  a_mode_onehot: assert property (@(posedge clk) disable iff (!rstn)
    $onehot(mode_oh)) else $error("mode select not one-hot");
  a_mode_idle: assert property (@(posedge clk) disable iff (!rstn)
    !$stable(mode_oh) |-> !$past(busy_s)) else $error("mode changed while busy");
  a_rx_pause: assert property (@(posedge link_clk) disable iff (!rstn)
    st == S_RX && ce_l && (hold_l || rx_pend) |=> cable.rdy_strb_n)
    else $error("ready held during pause");
  a_rx_capture: assert property (@(posedge link_clk) disable iff (!rstn)
    st == S_RX && ce_l && dstr_ev |=> rx_tgl != $past(rx_tgl) && rxw == $past(dd_2))
    else $error("strobe edge word lost");
  a_bus_owner: assert property (@(posedge link_clk) disable iff (!rstn)
    (st == S_TX |-> cable.dd_oe) and (st == S_RX |-> !cable.dd_oe))
    else $error("data bus owner wrong");
  a_term_lines: assert property (@(posedge link_clk) disable iff (!rstn)
    st == S_TERM |-> cable.stop && cable.rdy_strb_n && !cable.ack_n)
    else $error("termination levels wrong");
  a_idle_revert: assert property (@(posedge link_clk) disable iff (!rstn)
    st == S_IDLE |-> cable.ack_n && cable.stop && cable.rdy_strb_n && !cable.dd_oe)
    else $error("idle levels wrong");
  a_crc_drive: assert property (@(posedge link_clk) disable iff (!rstn)
    st == S_TERM && ce_l && !rq_2 |=> s_crc_shown) else $error("crc not shown");
  a_ack_after_crc: assert property (@(posedge link_clk) disable iff (!rstn)
    s_ack_drop |-> $past(st) == S_CRC && cable.dd_oe && cable.dd_out == $past(cable.dd_out))
    else $error("ack dropped without crc");
  a_tx_strobe: assert property (@(posedge link_clk) disable iff (!rstn)
    st == S_TX && !$stable(cable.rdy_strb_n) |-> $past(ld) && $past(ddm_rdy))
    else $error("strobe toggled without word");
  a_start_ack: assert property (@(posedge link_clk) disable iff (!rstn)
    st == S_IDLE && ce_l && en_l && rq_2 |=> !cable.ack_n && st == S_ACK)
    else $error("request not acknowledged");

endmodule : uhb_port

// >>> uhb_dummy_unused.sv
`timescale 1ns/1ns

// >>> uhb_drive.sv
`timescale 1ns/1ns
module uhb_drive
  import uhb_pkg::*;
(
  input  wire logic       link_clk,
  input  wire uhb_cable_s cable,
  output logic            req,
  output logic            rdy_strb,
  output logic [15:0]     dd
);
  logic [15:0] tx_q[$];
  logic [15:0] got_q[$];
  logic [15:0] crc_seen;
  logic        last_s = 1'b1;
  bit          drv_dd;
  bit          wr_on;
  int          bad;
  initial begin
    req = 1'b0;
    rdy_strb = 1'b1;
    dd = 16'h0000;
  end
  always @(posedge link_clk) begin
    if (!drv_dd) dd <= ~dd;
    if (drv_dd && cable.dd_oe) bad++;
    if (wr_on && cable.rdy_strb_n != last_s && !cable.stop && !cable.ack_n)
      got_q.push_back(cable.dd_out);
    last_s <= cable.rdy_strb_n;
  end
  always @(posedge cable.ack_n) crc_seen = cable.dd_out;
  task automatic go();
    req <= 1'b1;
    for (int k = 0; k < 999 && (cable.ack_n || cable.stop); k++) @(posedge link_clk);
  endtask : go
  task automatic fin();
    repeat (4) @(posedge link_clk);
    req <= 1'b0;
    drv_dd <= 1'b0;
    for (int k = 0; k < 999 && !cable.ack_n; k++) @(posedge link_clk);
  endtask : fin
  task automatic rd(input bit hend);
    go();
    drv_dd <= 1'b1;
    @(posedge link_clk);
    while (tx_q.size() > 0) begin
      for (int k = 0; k < 999 && cable.rdy_strb_n; k++) @(posedge link_clk);
      dd <= tx_q.pop_front();
      repeat (4) @(posedge link_clk);
      rdy_strb <= ~rdy_strb;
      repeat (8) @(posedge link_clk);
    end
    for (int k = 0; k < 999 && hend && !cable.stop; k++) @(posedge link_clk);
    fin();
    rdy_strb <= 1'b1;
  endtask : rd
  task automatic wr(input int n, input bit hend);
    got_q.delete();
    wr_on = 1'b1;
    go();
    rdy_strb <= 1'b0;
    for (int k = 0; k < 3000 && !(hend ? cable.stop : got_q.size() >= n); k++) begin
      if (k == 40) rdy_strb <= 1'b1;
      if (k == 70) rdy_strb <= 1'b0;
      @(posedge link_clk);
    end
    rdy_strb <= 1'b1;
    fin();
    wr_on = 1'b0;
  endtask : wr
endmodule : uhb_drive

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top
  import uhb_pkg::*;
;
  logic        clk;
  logic        link_clk;
  logic        rstn;
  logic        ce;
  logic [1:0]  mode_sel;
  logic        mode_load, burst_en, wr_dir, stop_req, rx_hold, tx_valid;
  logic        tx_ready, rx_valid, busy, burst_done, req, rdy_strb;
  logic [15:0] tx_data, rx_data, dd;
  logic [2:0]  mode_oh;
  logic [2:0]  exp_mode;
  uhb_cable_s  cable;
  int          num_errors, comparisons, crc;
  logic [31:0] seed = 32'h00000e1b;
  logic [15:0] exp_q[$];

  uhb_port DUT (.clk(clk), .rstn(rstn), .ce(ce), .link_clk(link_clk), .mode_sel(mode_sel),
    .mode_load(mode_load), .burst_en(burst_en), .wr_dir(wr_dir), .stop_req(stop_req),
    .rx_hold(rx_hold), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .mode_oh(mode_oh), .busy(busy),
    .burst_done(burst_done), .drive_dma_request_pin(req), .dev_rdy_strb_pin(rdy_strb),
    .dd_in(dd), .cable(cable));
  uhb_drive drv (.link_clk(link_clk), .cable(cable), .req(req), .rdy_strb(rdy_strb), .dd(dd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever begin
      #7 link_clk = 1'b1;
      #8 link_clk = 1'b0;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int crc_nx(input int c, input int d);
    int fb;
    for (int i = 15; i >= 0; i--) begin
      fb = ((c >> 15) ^ (d >> i)) & 1;
      c = ((c << 1) & 'hffff) ^ (fb ? int'(CRC_POLY) : 0);
    end
    return c;
  endfunction : crc_nx
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tmo(input string nm);
    chk(nm, 1, 0);
    give_verdict();
  endtask : tmo
  task automatic set_mode(input logic [1:0] m, input logic [2:0] exp);
    exp_mode = exp;
    @(posedge clk);
    mode_sel <= m;
    mode_load <= 1'b1;
    @(posedge clk);
    mode_load <= 1'b0;
    @(negedge clk);
    chk("mode_oh", exp, mode_oh);
  endtask : set_mode
  task automatic host(input bit wr, input bit hend, input int n);
    int k;
    int got;
    got = 0;
    if (wr) foreach (exp_q[i]) begin
      for (k = 0; k < 500 && tx_ready !== 1'b1; k++) @(negedge clk);
      if (k == 500) tmo("tx_ready");
      @(posedge clk);
      tx_data <= exp_q[i];
      tx_valid <= 1'b1;
      @(posedge clk);
      tx_valid <= 1'b0;
      @(negedge clk);
      chk("tx_ready", 0, tx_ready);
    end
    else for (k = 0; k < 5000 && got < n; k++) begin
      @(posedge clk);
      rx_hold <= (rnd() % 4 == 0);
      @(negedge clk);
      if (rx_valid === 1'b1) begin
        chk("rx_data", exp_q[got], rx_data);
        got++;
      end
    end
    if (!wr) chk("rx words", n, got);
    if (!wr && got < n) tmo("rx words");
    for (k = 0; k < 500 && tx_ready !== 1'b1; k++) @(negedge clk);
    if (k == 500) tmo("tx_ready");
    if (hend) begin
      chk("busy", 1, busy);
      set_mode(mode_sel == 2'h2 ? 2'h0 : mode_sel + 2'h1, exp_mode);
      @(posedge clk);
      stop_req <= 1'b1;
    end
    for (k = 0; k < 5000 && burst_done !== 1'b1; k++) @(negedge clk);
    if (k == 5000) tmo("burst_done");
    @(posedge clk);
    stop_req <= 1'b0;
    burst_en <= 1'b0;
    rx_hold <= 1'b0;
  endtask : host
  task automatic burst(input bit wr, input bit hend);
    int n;
    n = 3 + int'(rnd() % 4);
    crc = CRC_SEED;
    exp_q.delete();
    repeat (n) exp_q.push_back(16'(rnd()));
    if (!wr) drv.tx_q = exp_q;
    foreach (exp_q[i]) crc = crc_nx(crc, exp_q[i]);
    @(posedge clk);
    wr_dir <= wr;
    burst_en <= 1'b1;
    fork
      if (wr) drv.wr(n, hend);
      else drv.rd(hend);
      host(wr, hend, n);
    join
    if (wr) chk("wr words", n, drv.got_q.size());
    if (wr) foreach (exp_q[i]) chk("wr word", exp_q[i], drv.got_q[i]);
    chk("crc", crc, drv.crc_seen);
    chk("bus clash", 0, drv.bad);
    repeat (3) @(negedge clk);
    chk("idle", 32'h0000000e, {cable.ack_n, cable.stop, cable.rdy_strb_n, cable.dd_oe});
    chk("busy", 0, busy);
  endtask : burst

  initial begin
    {rstn, mode_sel, mode_load, burst_en, wr_dir, stop_req, rx_hold, tx_valid} = '0;
    ce = 1'b1;
    tx_data = 16'h0000;
    num_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("mode reset", MODE_RST, mode_oh);
    chk("idle", 32'h0000000e, {cable.ack_n, cable.stop, cable.rdy_strb_n, cable.dd_oe});
    repeat (4) @(posedge clk);
    for (int m = 0; m < 4; m++) set_mode(m[1:0], m[1:0] == MODE_BAD ? 3'h4 : 3'h1 << m);
    @(posedge clk);
    ce <= 1'b0;
    set_mode(2'h0, 3'h4);
    @(posedge clk);
    ce <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      set_mode(m[1:0], 3'h1 << m);
      for (int b = 0; b < 4; b++) burst(b[1], b[0]);
    end
    give_verdict();
  end
endmodule : tb_top
